// ===== rtl/pgg_pkg.sv
// Purpose: Constants and types for the port group six/seven GPIO block
// Assumes: 16-bit registers on word-aligned Avalon-MM offsets
// Notes:   Reset values are all zero
package pgg_pkg;
	// -----------------------------------------------------------------
	// Register offsets (word index)
	// -----------------------------------------------------------------
	localparam logic [4:0] OFS_G6_DATA  = 5'h00;
	localparam logic [4:0] OFS_G6_IOEN  = 5'h01;
	localparam logic [4:0] OFS_G6_PULL  = 5'h02;
	localparam logic [4:0] OFS_G6_IFLG  = 5'h03;
	localparam logic [4:0] OFS_G6_ICTL  = 5'h04;
	localparam logic [4:0] OFS_G6_DBNC  = 5'h05;
	localparam logic [4:0] OFS_G6_MODE  = 5'h06;
	localparam logic [4:0] OFS_G6_FUNC  = 5'h07;
	localparam logic [4:0] OFS_G7_DATA  = 5'h08;
	localparam logic [4:0] OFS_G7_IOEN  = 5'h09;
	localparam logic [4:0] OFS_G7_PULL  = 5'h0A;
	localparam logic [4:0] OFS_G7_IFLG  = 5'h0B;
	localparam logic [4:0] OFS_G7_ICTL  = 5'h0C;
	localparam logic [4:0] OFS_G7_DBNC  = 5'h0D;
	localparam logic [4:0] OFS_G7_MODE  = 5'h0E;
	localparam logic [4:0] OFS_G7_FUNC  = 5'h0F;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h11;
	// -----------------------------------------------------------------
	// Field layout, reset and timing
	// -----------------------------------------------------------------
	localparam int          HI_POS      = 8;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [1:0]  FUNC_ZERO   = 2'h0;
	localparam logic [1:0]  FUNC_THREE  = 2'h3;
	localparam int          DBNC_NS     = 1000;
	localparam int          CLK_NS      = 8;
	localparam int          DBNC_CYC    = (DBNC_NS + CLK_NS - 1) / CLK_NS;
	// Peripheral signals of the first group
	typedef struct packed {
		logic [7:0] seg;
		logic       clk_a;
		logic       clk_b;
		logic       remote;
		logic       frame;
	} pgg_periph_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RESP = 2'b10
	} pgg_bus_t;
endpackage

// ===== rtl/pgg_gpio.sv
// Purpose: Two GPIO port groups (eight and four pins) with pin interrupts
// Assumes: Single 125 MHz clock, Avalon-MM slave with waitrequest
// Notes:   Pin inputs pass three flops before use (two for the converter trigger)
// Notes on behaviour
// - The first group has eight pins with GPIO and interrupts, each control field eight bits wide except the 16-bit function code field.
// - The second group has four pins with four-bit fields (8-bit function code field) and all other bits read as zero.
// - A pin interrupt flag clears only when software writes one to its bit; the two group status bits clear when read.
// - Mode bit zero gives GPIO, mode bit one picks peripheral function 0 to 3 from the pin's 2-bit code.
// - First group function 3 drives segments 15 to 8, function 0 drives clocks, remote, frame and trigger.
// - Second group function 3 drives segments 7 to 4, functions 0 to 2 have nothing assigned.
// - All control fields reset to zero and the input data field is read-only.
`timescale 1ns/100ps
module pgg_gpio #(
	parameter int N6 = 8,
	parameter int N7 = 4
) (
	// Clock and reset
	input  wire logic               clk_sys_in,
	input  wire logic               rstn_in,
	// Avalon-MM slave
	input  wire logic [4:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [31:0]        avs_writedata_in,
	input  wire logic [3:0]         avs_byteenable_in,
	output logic      [31:0]        avs_readdata_out,
	output logic                    avs_waitrequest_out,
	// Pins of the first group
	input  wire logic [N6-1:0]      grp6_pin_in,
	output logic      [N6-1:0]      grp6_pin_out,
	output logic      [N6-1:0]      grp6_pin_oe_n_out,
	output logic      [N6-1:0]      grp6_pull_en_out,
	output logic      [N6-1:0]      grp6_pull_up_out,
	// Pins of the second group
	input  wire logic [N7-1:0]      grp7_pin_in,
	output logic      [N7-1:0]      grp7_pin_out,
	output logic      [N7-1:0]      grp7_pin_oe_n_out,
	output logic      [N7-1:0]      grp7_pull_en_out,
	output logic      [N7-1:0]      grp7_pull_up_out,
	// Peripheral side
	input  wire pgg_pkg::pgg_periph_t periph_in,
	input  wire logic [3:0]         lcd_segment_lo_in,
	output logic                    converter_trigger_out,
	// Interrupts
	output logic                    grp6_irq_out,
	output logic                    grp7_irq_out,
	output logic                    irq_out
);
	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [7:0]  grp6_out_value_reg, grp6_input_enable_reg, grp6_output_enable_reg;
	logic [7:0]  grp6_pull_direction_reg, grp6_pull_enable_reg, grp6_irq_flag_reg;
	logic [7:0]  grp6_edge_select_reg, grp6_irq_enable_reg, grp6_debounce_on_reg;
	logic [7:0]  grp6_periph_mode_reg;
	logic [15:0] grp6_pin_function_code_reg;
	logic [3:0]  grp7_out_value_reg, grp7_input_enable_reg, grp7_output_enable_reg;
	logic [3:0]  grp7_pull_direction_reg, grp7_pull_enable_reg, grp7_irq_flag_reg;
	logic [3:0]  grp7_edge_select_reg, grp7_irq_enable_reg, grp7_debounce_on_reg;
	logic [3:0]  grp7_periph_mode_reg;
	logic [7:0]  grp7_pin_function_code_reg;
	logic [1:0]  irq_stat_reg, irq_mask_reg;
	logic [11:0] sync1_reg, sync2_reg, filt_reg, prev_reg;
	logic [11:0] cnt_hit;
	logic [9:0]  dbnc_cnt_reg [12];
	pgg_pkg::pgg_bus_t bus_state_reg;
	logic [7:0]  grp6_in_value, grp6_rise, grp6_fall, grp6_event;
	logic [3:0]  grp7_in_value, grp7_rise, grp7_fall, grp7_event;
	logic        wr_lo, wr_hi, wr_acc, rd_acc;
	logic [11:0] dbnc_on;
	logic [15:0] rd_word;

	function automatic logic [1:0] code_of(input logic [15:0] codes, input int idx);
		code_of = codes[2*idx +: 2];
	endfunction

	// -----------------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------------
	// Writes land at the edge where waitrequest is sampled low
	assign wr_acc = avs_write_in && (bus_state_reg == pgg_pkg::BUS_RESP);
	assign rd_acc = avs_read_in && (bus_state_reg == pgg_pkg::BUS_IDLE);
	assign wr_lo  = wr_acc && avs_byteenable_in[0];
	assign wr_hi  = wr_acc && avs_byteenable_in[1];

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_state_reg       <= pgg_pkg::BUS_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h00000000;
		end else begin
			case (bus_state_reg)
				pgg_pkg::BUS_IDLE: begin
					if (avs_read_in || avs_write_in) begin
						bus_state_reg       <= pgg_pkg::BUS_RESP;
						avs_waitrequest_out <= 1'b0;
						avs_readdata_out    <= {16'h0000, rd_word};
					end
				end
				pgg_pkg::BUS_RESP: begin
					bus_state_reg       <= pgg_pkg::BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
				default: bus_state_reg <= pgg_pkg::BUS_IDLE;
			endcase
		end
	end

	always_comb begin
		rd_word = pgg_pkg::RST_WORD;
		case (avs_address_in)
			pgg_pkg::OFS_G6_DATA:  rd_word = {grp6_out_value_reg, grp6_in_value};
			pgg_pkg::OFS_G6_IOEN:  rd_word = {grp6_input_enable_reg, grp6_output_enable_reg};
			pgg_pkg::OFS_G6_PULL:  rd_word = {grp6_pull_direction_reg, grp6_pull_enable_reg};
			pgg_pkg::OFS_G6_IFLG:  rd_word = {8'h00, grp6_irq_flag_reg};
			pgg_pkg::OFS_G6_ICTL:  rd_word = {grp6_edge_select_reg, grp6_irq_enable_reg};
			pgg_pkg::OFS_G6_DBNC:  rd_word = {8'h00, grp6_debounce_on_reg};
			pgg_pkg::OFS_G6_MODE:  rd_word = {8'h00, grp6_periph_mode_reg};
			pgg_pkg::OFS_G6_FUNC:  rd_word = grp6_pin_function_code_reg;
			pgg_pkg::OFS_G7_DATA:  rd_word = {4'h0, grp7_out_value_reg, 4'h0, grp7_in_value};
			pgg_pkg::OFS_G7_IOEN:  rd_word = {4'h0, grp7_input_enable_reg, 4'h0, grp7_output_enable_reg};
			pgg_pkg::OFS_G7_PULL:  rd_word = {4'h0, grp7_pull_direction_reg, 4'h0, grp7_pull_enable_reg};
			pgg_pkg::OFS_G7_IFLG:  rd_word = {12'h000, grp7_irq_flag_reg};
			pgg_pkg::OFS_G7_ICTL:  rd_word = {4'h0, grp7_edge_select_reg, 4'h0, grp7_irq_enable_reg};
			pgg_pkg::OFS_G7_DBNC:  rd_word = {12'h000, grp7_debounce_on_reg};
			pgg_pkg::OFS_G7_MODE:  rd_word = {12'h000, grp7_periph_mode_reg};
			pgg_pkg::OFS_G7_FUNC:  rd_word = {8'h00, grp7_pin_function_code_reg};
			pgg_pkg::OFS_IRQ_STAT: rd_word = {14'h0000, irq_stat_reg};
			pgg_pkg::OFS_IRQ_MASK: rd_word = {14'h0000, irq_mask_reg};
			default:               rd_word = pgg_pkg::RST_WORD;
		endcase
	end

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grp6_out_value_reg         <= pgg_pkg::RST_BYTE;
			grp6_input_enable_reg      <= pgg_pkg::RST_BYTE;
			grp6_output_enable_reg     <= pgg_pkg::RST_BYTE;
			grp6_pull_direction_reg    <= pgg_pkg::RST_BYTE;
			grp6_pull_enable_reg       <= pgg_pkg::RST_BYTE;
			grp6_edge_select_reg       <= pgg_pkg::RST_BYTE;
			grp6_irq_enable_reg        <= pgg_pkg::RST_BYTE;
			grp6_debounce_on_reg       <= pgg_pkg::RST_BYTE;
			grp6_periph_mode_reg       <= pgg_pkg::RST_BYTE;
			grp6_pin_function_code_reg <= pgg_pkg::RST_WORD;
			grp7_out_value_reg         <= 4'h0;
			grp7_input_enable_reg      <= 4'h0;
			grp7_output_enable_reg     <= 4'h0;
			grp7_pull_direction_reg    <= 4'h0;
			grp7_pull_enable_reg       <= 4'h0;
			grp7_edge_select_reg       <= 4'h0;
			grp7_irq_enable_reg        <= 4'h0;
			grp7_debounce_on_reg       <= 4'h0;
			grp7_periph_mode_reg       <= 4'h0;
			grp7_pin_function_code_reg <= 8'h00;
			irq_mask_reg               <= 2'h0;
		end else begin
			if (wr_hi) begin
				case (avs_address_in)
					pgg_pkg::OFS_G6_DATA: grp6_out_value_reg      <= avs_writedata_in[15:8];
					pgg_pkg::OFS_G6_IOEN: grp6_input_enable_reg   <= avs_writedata_in[15:8];
					pgg_pkg::OFS_G6_PULL: grp6_pull_direction_reg <= avs_writedata_in[15:8];
					pgg_pkg::OFS_G6_ICTL: grp6_edge_select_reg    <= avs_writedata_in[15:8];
					pgg_pkg::OFS_G6_FUNC: grp6_pin_function_code_reg[15:8] <= avs_writedata_in[15:8];
					pgg_pkg::OFS_G7_DATA: grp7_out_value_reg      <= avs_writedata_in[11:8];
					pgg_pkg::OFS_G7_IOEN: grp7_input_enable_reg   <= avs_writedata_in[11:8];
					pgg_pkg::OFS_G7_PULL: grp7_pull_direction_reg <= avs_writedata_in[11:8];
					pgg_pkg::OFS_G7_ICTL: grp7_edge_select_reg    <= avs_writedata_in[11:8];
					default: ;
				endcase
			end
			if (wr_lo) begin
				case (avs_address_in)
					pgg_pkg::OFS_G6_IOEN: grp6_output_enable_reg  <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G6_PULL: grp6_pull_enable_reg    <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G6_ICTL: grp6_irq_enable_reg     <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G6_DBNC: grp6_debounce_on_reg    <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G6_MODE: grp6_periph_mode_reg    <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G6_FUNC: grp6_pin_function_code_reg[7:0] <= avs_writedata_in[7:0];
					pgg_pkg::OFS_G7_IOEN: grp7_output_enable_reg  <= avs_writedata_in[3:0];
					pgg_pkg::OFS_G7_PULL: grp7_pull_enable_reg    <= avs_writedata_in[3:0];
					pgg_pkg::OFS_G7_ICTL: grp7_irq_enable_reg     <= avs_writedata_in[3:0];
					pgg_pkg::OFS_G7_DBNC: grp7_debounce_on_reg    <= avs_writedata_in[3:0];
					pgg_pkg::OFS_G7_MODE: grp7_periph_mode_reg    <= avs_writedata_in[3:0];
					pgg_pkg::OFS_G7_FUNC: grp7_pin_function_code_reg <= avs_writedata_in[7:0];
					pgg_pkg::OFS_IRQ_MASK: irq_mask_reg           <= avs_writedata_in[1:0];
					default: ;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// Input synchroniser and chatter filter
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
		end else begin
			sync1_reg <= {grp7_pin_in, grp6_pin_in};
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			filt_reg <= 12'h000;
			prev_reg <= 12'h000;
			for (int i = 0; i < 12; i++) begin
				dbnc_cnt_reg[i] <= 10'h000;
			end
		end else begin
			prev_reg <= filt_reg;
			for (int i = 0; i < 12; i++) begin
				if (!dbnc_on[i]) begin
					filt_reg[i]     <= sync2_reg[i];
					dbnc_cnt_reg[i] <= 10'h000;
				end else if (sync2_reg[i] == filt_reg[i]) begin
					dbnc_cnt_reg[i] <= 10'h000;
				end else if (cnt_hit[i]) begin
					filt_reg[i]     <= sync2_reg[i];
					dbnc_cnt_reg[i] <= 10'h000;
				end else begin
					dbnc_cnt_reg[i] <= dbnc_cnt_reg[i] + 10'h001;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 12; i++) begin
			cnt_hit[i] = (dbnc_cnt_reg[i] == 10'(pgg_pkg::DBNC_CYC - 1));
		end
	end

	assign dbnc_on       = {grp7_debounce_on_reg, grp6_debounce_on_reg};
	assign grp6_in_value = filt_reg[7:0] & grp6_input_enable_reg;
	assign grp7_in_value = filt_reg[11:8] & grp7_input_enable_reg;

	// -----------------------------------------------------------------
	// Pin interrupts
	// -----------------------------------------------------------------
	assign grp6_rise  = grp6_in_value & ~prev_reg[7:0];
	assign grp6_fall  = ~grp6_in_value & prev_reg[7:0] & grp6_input_enable_reg;
	assign grp6_event = (grp6_edge_select_reg & grp6_fall) | (~grp6_edge_select_reg & grp6_rise);
	assign grp7_rise  = grp7_in_value & ~prev_reg[11:8];
	assign grp7_fall  = ~grp7_in_value & prev_reg[11:8] & grp7_input_enable_reg;
	assign grp7_event = (grp7_edge_select_reg & grp7_fall) | (~grp7_edge_select_reg & grp7_rise);

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grp6_irq_flag_reg <= pgg_pkg::RST_BYTE;
			grp7_irq_flag_reg <= 4'h0;
		end else begin
			grp6_irq_flag_reg <= (grp6_irq_flag_reg & ~((wr_lo && avs_address_in == pgg_pkg::OFS_G6_IFLG)
				? avs_writedata_in[7:0] : 8'h00)) | grp6_event;
			grp7_irq_flag_reg <= (grp7_irq_flag_reg & ~((wr_lo && avs_address_in == pgg_pkg::OFS_G7_IFLG)
				? avs_writedata_in[3:0] : 4'h0)) | grp7_event;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grp6_irq_out <= 1'b0;
			grp7_irq_out <= 1'b0;
			irq_stat_reg <= 2'h0;
			irq_out      <= 1'b0;
		end else begin
			grp6_irq_out <= |(grp6_irq_flag_reg & grp6_irq_enable_reg);
			grp7_irq_out <= |(grp7_irq_flag_reg & grp7_irq_enable_reg);
			irq_stat_reg <= ((rd_acc && avs_address_in == pgg_pkg::OFS_IRQ_STAT) ? 2'h0 : irq_stat_reg)
				| {|(grp7_event & grp7_irq_enable_reg), |(grp6_event & grp6_irq_enable_reg)};
			irq_out      <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// -----------------------------------------------------------------
	// Pin function multiplexer
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grp6_pin_out          <= 8'h00;
			grp6_pin_oe_n_out     <= 8'hFF;
			grp7_pin_out          <= 4'h0;
			grp7_pin_oe_n_out     <= 4'hF;
			converter_trigger_out <= 1'b1;
		end else begin
			converter_trigger_out <= 1'b1;
			for (int i = 0; i < 8; i++) begin
				grp6_pin_out[i]      <= grp6_out_value_reg[i];
				grp6_pin_oe_n_out[i] <= ~grp6_output_enable_reg[i];
				if (grp6_periph_mode_reg[i]) begin
					grp6_pin_out[i]      <= 1'b0;
					grp6_pin_oe_n_out[i] <= 1'b1;
					if (code_of(grp6_pin_function_code_reg, i) == pgg_pkg::FUNC_THREE) begin
						grp6_pin_out[i]      <= periph_in.seg[7-i];
						grp6_pin_oe_n_out[i] <= 1'b0;
					end else if (code_of(grp6_pin_function_code_reg, i) == pgg_pkg::FUNC_ZERO && i < 4) begin
						grp6_pin_out[i]      <= (i == 0) ? periph_in.clk_a : (i == 1) ? periph_in.clk_b
							: (i == 2) ? periph_in.remote : periph_in.frame;
						grp6_pin_oe_n_out[i] <= 1'b0;
					end
				end
			end
			if (grp6_periph_mode_reg[4] && code_of(grp6_pin_function_code_reg, 4) == pgg_pkg::FUNC_ZERO) begin
				converter_trigger_out <= sync2_reg[4];
			end
			for (int j = 0; j < 4; j++) begin
				grp7_pin_out[j]      <= grp7_out_value_reg[j];
				grp7_pin_oe_n_out[j] <= ~grp7_output_enable_reg[j];
				if (grp7_periph_mode_reg[j]) begin
					grp7_pin_out[j]      <= 1'b0;
					grp7_pin_oe_n_out[j] <= 1'b1;
					if (code_of({8'h00, grp7_pin_function_code_reg}, j) == pgg_pkg::FUNC_THREE) begin
						grp7_pin_out[j]      <= lcd_segment_lo_in[3-j];
						grp7_pin_oe_n_out[j] <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grp6_pull_en_out <= 8'h00;
			grp6_pull_up_out <= 8'h00;
			grp7_pull_en_out <= 4'h0;
			grp7_pull_up_out <= 4'h0;
		end else begin
			grp6_pull_en_out <= grp6_pull_enable_reg & ~grp6_output_enable_reg & ~grp6_periph_mode_reg;
			grp6_pull_up_out <= grp6_pull_direction_reg;
			grp7_pull_en_out <= grp7_pull_enable_reg & ~grp7_output_enable_reg & ~grp7_periph_mode_reg;
			grp7_pull_up_out <= grp7_pull_direction_reg;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_flag_w1c: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(wr_lo && avs_address_in == pgg_pkg::OFS_G6_IFLG && avs_writedata_in[0] && !grp6_event[0])
		|=> !grp6_irq_flag_reg[0]) else $error("flag not cleared by one write");
	a_flag_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(grp6_irq_flag_reg[1] && !(wr_lo && avs_address_in == pgg_pkg::OFS_G6_IFLG && avs_writedata_in[1]))
		|=> grp6_irq_flag_reg[1]) else $error("flag lost without clear");
	a_edge_set: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		grp6_event[2] |=> grp6_irq_flag_reg[2]) else $error("edge did not set flag");
	a_irq_req: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		|(grp7_irq_flag_reg & grp7_irq_enable_reg) |=> grp7_irq_out) else $error("group irq missing");
	a_grp7_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(avs_address_in == pgg_pkg::OFS_G7_DATA) |-> (rd_word[15:12] == 4'h0 && rd_word[7:4] == 4'h0))
		else $error("unused bits not zero");
	a_gpio_mode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!grp6_periph_mode_reg[5] |=> (grp6_pin_oe_n_out[5] == !$past(grp6_output_enable_reg[5])))
		else $error("gpio enable not routed");
	a_seg_map: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(grp6_periph_mode_reg[0] && code_of(grp6_pin_function_code_reg, 0) == pgg_pkg::FUNC_THREE)
		|=> (grp6_pin_out[0] == $past(periph_in.seg[7]) && !grp6_pin_oe_n_out[0])) else $error("segment map");
	a_grp7_none: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(grp7_periph_mode_reg[1] && code_of({8'h00, grp7_pin_function_code_reg}, 1) != pgg_pkg::FUNC_THREE)
		|=> grp7_pin_oe_n_out[1]) else $error("unassigned function drives");
	a_bus_resp: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		((avs_read_in || avs_write_in) && bus_state_reg == pgg_pkg::BUS_IDLE) |=> !avs_waitrequest_out ##1
		avs_waitrequest_out) else $error("bus answer timing");
endmodule

// ===== verification/pgg_pin_model.sv
// Purpose: Pad level model for one port group
// Assumes: Chip drive wins, then external drive, then pull
// Notes:   A pad left floating toggles every cycle
`timescale 1ns/100ps
module pgg_pin_model #(
	parameter int N = 8
) (
	// Chip side
	input  wire logic         clk_sys_in,
	input  wire logic [N-1:0] pin_out_in,
	input  wire logic [N-1:0] oe_n_in,
	input  wire logic [N-1:0] pull_en_in,
	input  wire logic [N-1:0] pull_up_in,
	// External drive
	input  wire logic [N-1:0] ext_en_in,
	input  wire logic [N-1:0] ext_val_in,
	output logic      [N-1:0] pad_out
);
	logic [N-1:0] float_val;
	initial begin
		float_val = '0;
		forever @(posedge clk_sys_in) float_val <= ~float_val;
	end
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (!oe_n_in[i])
				pad_out[i] = pin_out_in[i];
			else if (ext_en_in[i])
				pad_out[i] = ext_val_in[i];
			else if (pull_en_in[i])
				pad_out[i] = pull_up_in[i];
			else
				pad_out[i] = float_val[i];
		end
	end
endmodule

// ===== verification/port_group_six_seven_gpio_test.sv
// Purpose: Self-checking bench for the port group GPIO block
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes:   One pad model per group resolves the pin levels
`timescale 1ns/100ps
module port_group_six_seven_gpio_test;
	logic        clk_sys_in, rstn_in, rd, wr, wt, trig, irq6, irq7, irq;
	logic [4:0]  adr;
	logic [31:0] wd, rdat, v;
	logic [3:0]  be, seg_lo, p7o, oe7, pe7, pu7, x7e, x7v, pad7;
	logic [7:0]  p6o, oe6, pe6, pu6, x6e, x6v, pad6;
	int          mismatches, tests_run, cyc;
	pgg_pkg::pgg_periph_t per;
	logic [4:0]  ta [8] = '{pgg_pkg::OFS_G6_IOEN, pgg_pkg::OFS_G7_IOEN, pgg_pkg::OFS_G6_FUNC, pgg_pkg::OFS_G7_FUNC,
		pgg_pkg::OFS_G7_DBNC, pgg_pkg::OFS_G7_MODE, pgg_pkg::OFS_G6_DATA, 5'h1F};
	logic [15:0] td [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFFFF};
	logic [15:0] te [8] = '{16'hFFFF, 16'h0F0F, 16'hFFFF, 16'h00FF, 16'h000F, 16'h000F, 16'h0000, 16'h0000};
	pgg_gpio #(.N6(8), .N7(4)) uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wt), .grp6_pin_in(pad6), .grp6_pin_out(p6o),
		.grp6_pin_oe_n_out(oe6), .grp6_pull_en_out(pe6), .grp6_pull_up_out(pu6), .grp7_pin_in(pad7),
		.grp7_pin_out(p7o), .grp7_pin_oe_n_out(oe7), .grp7_pull_en_out(pe7), .grp7_pull_up_out(pu7),
		.periph_in(per), .lcd_segment_lo_in(seg_lo), .converter_trigger_out(trig), .grp6_irq_out(irq6),
		.grp7_irq_out(irq7), .irq_out(irq));
	pgg_pin_model #(.N(8)) m6 (.clk_sys_in(clk_sys_in), .pin_out_in(p6o), .oe_n_in(oe6), .pull_en_in(pe6),
		.pull_up_in(pu6), .ext_en_in(x6e), .ext_val_in(x6v), .pad_out(pad6));
	pgg_pin_model #(.N(4)) m7 (.clk_sys_in(clk_sys_in), .pin_out_in(p7o), .oe_n_in(oe7), .pull_en_in(pe7),
		.pull_up_in(pu7), .ext_en_in(x7e), .ext_val_in(x7v), .pad_out(pad7));
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	task automatic report_and_stop;
		$display("mismatches %0d of %0d checks", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Avalon-MM access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk_sys_in);
		while (wt) @(posedge clk_sys_in);
		v = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(v, e);
	endtask
	initial begin
		{rd, wr, adr, wd, per, seg_lo, x6e, x6v, x7e, x7v} = '0;
		be = 4'h3;
		rstn_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		for (int a = 0; a < 18; a++) rchk(a[4:0], 32'h0);
		check({21'h0, oe6, irq, irq6, irq7}, 32'h7F8);
		check({oe6, p6o, pe6, pu6}, 32'hFF000000);
		check({oe7, p7o, pe7, pu7, 15'h0, trig}, 32'hF0000001);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, ta[i], {16'h0, td[i]});
			rchk(ta[i], {16'h0, te[i]});
		end
		bus(1'b1, pgg_pkg::OFS_G6_DATA, 32'hA500);
		repeat (6) @(posedge clk_sys_in);
		rchk(pgg_pkg::OFS_G6_DATA, 32'hA5A5);
		check({16'h0, oe6, p6o}, 32'h00A5);
		per <= '{seg: 8'h1D, clk_a: 1'b1, clk_b: 1'b0, remote: 1'b1, frame: 1'b1};
		bus(1'b1, pgg_pkg::OFS_G6_MODE, 32'h00FF);
		repeat (3) @(posedge clk_sys_in);
		check({16'h0, oe6, p6o}, 32'h00B8);
		bus(1'b1, pgg_pkg::OFS_G6_FUNC, 32'h0000);
		x6e <= 8'h10;
		repeat (6) @(posedge clk_sys_in);
		check({20'h0, oe6, p6o[3:0]}, 32'hF0D);
		check({31'h0, trig}, 32'h0);
		x6v <= 8'h10;
		repeat (6) @(posedge clk_sys_in);
		check({31'h0, trig}, 32'h1);
		seg_lo <= 4'h1;
		repeat (3) @(posedge clk_sys_in);
		check({24'h0, oe7, p7o}, 32'h08);
		bus(1'b1, pgg_pkg::OFS_G7_FUNC, 32'h0055);
		repeat (3) @(posedge clk_sys_in);
		check({28'h0, oe7}, 32'hF);
		// Pin interrupts on group six, pin zero
		bus(1'b1, pgg_pkg::OFS_G6_MODE, 32'h0);
		bus(1'b1, pgg_pkg::OFS_G6_IOEN, 32'hFF00);
		x6e <= 8'hFF;
		x6v <= 8'h00;
		bus(1'b1, pgg_pkg::OFS_G6_ICTL, 32'h0001);
		bus(1'b1, pgg_pkg::OFS_IRQ_MASK, 32'h0001);
		repeat (6) @(posedge clk_sys_in);
		bus(1'b1, pgg_pkg::OFS_G6_IFLG, 32'h00FF);
		bus(1'b0, pgg_pkg::OFS_IRQ_STAT, 32'h0);
		rchk(pgg_pkg::OFS_G6_IFLG, 32'h0);
		x6v <= 8'h01;
		repeat (10) @(posedge clk_sys_in);
		check({29'h0, irq, irq6, irq7}, 32'h6);
		rchk(pgg_pkg::OFS_G6_IFLG, 32'h1);
		bus(1'b1, pgg_pkg::OFS_G6_IFLG, 32'h00FE);
		rchk(pgg_pkg::OFS_G6_IFLG, 32'h1);
		rchk(pgg_pkg::OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk_sys_in);
		check({29'h0, irq, irq6, irq7}, 32'h2);
		bus(1'b1, pgg_pkg::OFS_G6_IFLG, 32'h0001);
		rchk(pgg_pkg::OFS_G6_IFLG, 32'h0);
		check({31'h0, irq6}, 32'h0);
		bus(1'b1, pgg_pkg::OFS_G6_ICTL, 32'h0101);
		x6v <= 8'h00;
		repeat (10) @(posedge clk_sys_in);
		rchk(pgg_pkg::OFS_G6_IFLG, 32'h1);
		// Pulls act only on undriven GPIO pins; the filter holds a new level back
		bus(1'b1, pgg_pkg::OFS_G6_PULL, 32'hFF0F);
		bus(1'b1, pgg_pkg::OFS_G7_PULL, 32'h0F0F);
		repeat (3) @(posedge clk_sys_in);
		check({16'h0, pe6, pu6}, 32'h0FFF);
		check({24'h0, pe7, pu7}, 32'h0F);
		bus(1'b1, pgg_pkg::OFS_G6_DBNC, 32'h0002);
		x6v <= 8'h02;
		repeat (60) @(posedge clk_sys_in);
		rchk(pgg_pkg::OFS_G6_DATA, 32'hA500);
		repeat (80) @(posedge clk_sys_in);
		rchk(pgg_pkg::OFS_G6_DATA, 32'hA502);
		report_and_stop;
	end
endmodule
